// File: hw/phy_mgmt_regs.sv
/*
 * management register bank: serial management slave plus control,
 * status and identifier registers.
 * assumes mdc and mdio_in are already synchronous to mclk and that
 * mdc is far slower than mclk.
 */
`timescale 1ns/100ps
`default_nettype none
module phy_mgmt_regs
	import phy_mgmt_pkg::*;
#(
	parameter logic [15:0] OUI_HIGH = 16'h1234 // arbitrary value
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// management bus
	input  wire logic       mdc,
	input  wire logic       mdio_in,
	output logic            mdio_out,
	output logic            mdio_oe,
	// strap
	input  wire logic [4:0] phy_addr_strap,
	// core conditions
	input  wire logic       an_done,
	input  wire logic       remote_fault,
	input  wire logic       link_up,
	input  wire logic       jabber,
	// core controls
	output logic            core_reset,
	output logic            loopback_en,
	output logic            speed_100,
	output logic            an_enable,
	output logic            low_power,
	output logic            isolate,
	output logic            an_restart,
	output logic            full_duplex
);
	localparam int RST_LEN = SOFT_RST_CYC;

	mgmt_state_type state_reg, state_next; // frame position
	logic [5:0]  cnt_reg, cnt_next;        // bit / preamble count
	logic [11:0] hdr_reg, hdr_next;        // op, address, register
	logic [15:0] sh_reg, sh_next;          // data shifter
	logic        out_reg, out_next;        // mdio drive value
	logic        oe_reg, oe_next;          // mdio drive enable
	logic        mdc_reg;                  // previous mdc
	logic        mdc_rise;                 // sample point
	logic [11:0] hdr_full;                 // header incl. last bit
	logic        sts_read;                 // status read taken
	logic        wr_ctl;                   // control write commit
	logic [15:0] wdat;                     // write data
	logic [15:0] rd_val;                   // read mux
	logic [15:0] sts_val;                  // status image
	logic [4:0]  addr_reg, addr_next;      // strapped address
	logic [15:0] ctl_reg, ctl_next;        // control register
	logic [15:0] ctl_def;                  // control defaults
	logic [7:0]  rst_reg, rst_next;        // soft reset countdown
	logic        an_lh_reg, an_lh_next;    // latched complete
	logic        rf_lh_reg, rf_lh_next;    // latched fault
	logic        jab_lh_reg, jab_lh_next;  // latched jabber
	logic        link_ll_reg, link_ll_next;// latched link

	// mdc edge detect; inputs count as synchronous already
	// no reset needed: the flop follows mdc every cycle, reset or not
	always_ff @(posedge mclk) begin
		mdc_reg <= mdc;
	end
	assign mdc_rise = mdc & ~mdc_reg;
	assign hdr_full = {hdr_reg[10:0], mdio_in};
	assign wdat     = {sh_reg[14:0], mdio_in};

	// status image: fixed abilities plus latched bits
	always_comb begin
		sts_val = STS_FIXED;
		sts_val[STS_AN_DONE] = an_lh_reg;
		sts_val[STS_RFAULT]  = rf_lh_reg;
		sts_val[STS_LINK]    = link_ll_reg;
		sts_val[STS_JABBER]  = jab_lh_reg;
	end

	// read mux; unmapped registers read zero
	always_comb begin
		unique case (hdr_full[4:0])
			REG_CONTROL: rd_val = ctl_reg;
			REG_STATUS:  rd_val = sts_val;
			REG_IDHIGH:  rd_val = OUI_HIGH;
			default:     rd_val = 16'h0000;
		endcase
	end

	// management frame decode, advanced on mdc rising edges
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		hdr_next   = hdr_reg;
		sh_next    = sh_reg;
		out_next   = out_reg;
		oe_next    = oe_reg;
		sts_read   = 1'b0;
		wr_ctl     = 1'b0;
		if (!resetn) begin
			state_next = ST_HUNT;
			cnt_next   = 6'h00;
			hdr_next   = 12'h000;
			sh_next    = 16'h0000;
			out_next   = 1'b0;
			oe_next    = 1'b0;
		end else if (mdc_rise) begin
			unique case (state_reg)
				ST_HUNT: begin
					// a frame counts only after a full preamble
					if (mdio_in) begin
						if (cnt_reg != PRE_ONES)
							cnt_next = cnt_reg + 6'h01;
					end else if (cnt_reg == PRE_ONES) begin
						state_next = ST_START;
					end else begin
						cnt_next = 6'h00;
					end
				end
				ST_START: begin
					cnt_next   = 6'h00;
					state_next = mdio_in ? ST_HDR : ST_HUNT;
				end
				ST_HDR: begin
					hdr_next = hdr_full;
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == HDR_LAST) begin
						cnt_next   = 6'h00;
						state_next = ST_HUNT;
						if (hdr_full[9:5] == addr_reg) begin
							if (hdr_full[11:10] == OP_READ) begin
								// snapshot before latches refresh
								sh_next    = rd_val;
								sts_read   = hdr_full[4:0] == REG_STATUS;
								state_next = ST_TA1;
							end else if (hdr_full[11:10] == OP_WRITE) begin
								state_next = ST_WTA;
							end
						end
					end
				end
				ST_TA1: begin
					// manager has released; drive the zero
					state_next = ST_TA2;
					oe_next    = 1'b1;
					out_next   = 1'b0;
				end
				ST_TA2, ST_RDATA: begin
					out_next   = sh_reg[15];
					sh_next    = {sh_reg[14:0], 1'b0};
					state_next = ST_RDATA;
					if (state_reg == ST_TA2) begin
						cnt_next = 6'h00;
					end else if (cnt_reg == DATA_LAST) begin
						oe_next    = 1'b0;
						out_next   = 1'b0;
						state_next = ST_HUNT;
						cnt_next   = 6'h00;
					end else begin
						cnt_next = cnt_reg + 6'h01;
					end
				end
				ST_WTA: begin
					// two turnaround bits, not checked
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == 6'h01) begin
						cnt_next   = 6'h00;
						state_next = ST_WDATA;
					end
				end
				ST_WDATA: begin
					sh_next  = wdat;
					cnt_next = cnt_reg + 6'h01;
					if (cnt_reg == DATA_LAST) begin
						wr_ctl     = hdr_reg[4:0] == REG_CONTROL;
						cnt_next   = 6'h00;
						state_next = ST_HUNT;
					end
				end
			endcase
		end
	end

	// control register with timed self-clearing reset
	always_comb begin
		addr_next = addr_reg;
		ctl_def   = CTL_DEFAULT;
		ctl_def[CTL_ISOLATE] = addr_reg == 5'h00;
		ctl_next  = ctl_reg;
		ctl_next[CTL_RESTART] = 1'b0;
		rst_next  = rst_reg;
		if (!resetn) begin
			// strap is caught while reset is held, then kept
			addr_next = phy_addr_strap;
			ctl_next  = CTL_DEFAULT;
			ctl_next[CTL_ISOLATE] = phy_addr_strap == 5'h00;
			rst_next  = 8'h00;
		end else if (rst_reg != 8'h00) begin
			// writes during the reset are dropped
			ctl_next = ctl_def;
			ctl_next[CTL_RESET] = rst_reg != 8'h01;
			rst_next = rst_reg - 8'h01;
		end else if (wr_ctl && wdat[CTL_RESET]) begin
			ctl_next = ctl_def;
			ctl_next[CTL_RESET] = 1'b1;
			rst_next = 8'(RST_LEN);
		end else if (wr_ctl) begin
			ctl_next = wdat & CTL_RW_MASK;
			// clearing isolate is ignored
			ctl_next[CTL_ISOLATE] =
				ctl_reg[CTL_ISOLATE] | wdat[CTL_ISOLATE];
			ctl_next[CTL_RESTART] = wdat[CTL_RESTART];
		end
	end

	// latched status; a new event beats the read refresh
	always_comb begin
		an_lh_next   = an_done | (an_lh_reg & ~sts_read);
		rf_lh_next   = remote_fault | (rf_lh_reg & ~sts_read);
		jab_lh_next  = jabber | (jab_lh_reg & ~sts_read);
		link_ll_next = link_up & (link_ll_reg | sts_read);
		if (!resetn) begin
			an_lh_next   = 1'b0;
			rf_lh_next   = 1'b0;
			jab_lh_next  = 1'b0;
			link_ll_next = 1'b0;
		end
	end

	// all state registers except the mdc edge flop
	always_ff @(posedge mclk) begin
		state_reg   <= state_next;
		cnt_reg     <= cnt_next;
		hdr_reg     <= hdr_next;
		sh_reg      <= sh_next;
		out_reg     <= out_next;
		oe_reg      <= oe_next;
		addr_reg    <= addr_next;
		ctl_reg     <= ctl_next;
		rst_reg     <= rst_next;
		an_lh_reg   <= an_lh_next;
		rf_lh_reg   <= rf_lh_next;
		jab_lh_reg  <= jab_lh_next;
		link_ll_reg <= link_ll_next;
	end

	// outputs straight from flops
	assign mdio_out    = out_reg;
	assign mdio_oe     = oe_reg;
	assign core_reset  = ctl_reg[CTL_RESET];
	assign loopback_en = ctl_reg[14];
	assign speed_100   = ctl_reg[13];
	assign an_enable   = ctl_reg[12];
	assign low_power   = ctl_reg[11];
	assign isolate     = ctl_reg[CTL_ISOLATE];
	assign an_restart  = ctl_reg[CTL_RESTART];
	assign full_duplex = ctl_reg[8];

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_reset_len: assert property ($rose(core_reset) |->
		##RST_LEN !core_reset) else $error("soft reset length wrong");
	a_reset_defaults: assert property (core_reset |->
		an_enable && speed_100 && full_duplex && !loopback_en
		&& !low_power) else $error("defaults not held in reset");
	a_restart_pulse: assert property (an_restart |=>
		!an_restart) else $error("restart not self clearing");
	a_iso_sticky: assert property ($fell(isolate) |->
		core_reset) else $error("isolate cleared by write");
	a_ctl_low_zero: assert property (ctl_reg[6:0] == 7'h00)
		else $error("reserved control bits set");
	a_sts_fixed: assert property (sts_val[15:11] == 5'h0F
		&& !sts_val[6] && sts_val[3] && sts_val[0])
		else $error("fixed status bits wrong");
	a_jab_latch: assert property (jabber ##1 !jabber [*2]
		|-> jab_lh_reg || $past(sts_read)) else $error("jabber lost");
	a_link_low: assert property (!link_up |=>
		!link_ll_reg) else $error("link loss not latched");
	a_an_latch: assert property (an_done |=> an_lh_reg)
		else $error("complete not latched");
	a_fault_latch: assert property (remote_fault |=>
		rf_lh_reg) else $error("fault not latched");
	a_ta_drive: assert property (mdc_rise && state_reg == ST_TA1
		|=> mdio_oe && !mdio_out) else $error("turnaround zero missing");
	// a status read reloads each latch from the present condition
	a_link_reload: assert property (sts_read && link_up |=>
		link_ll_reg) else $error("link latch not reloaded");
	a_an_clear: assert property (sts_read && !an_done |=>
		!an_lh_reg) else $error("complete latch not cleared");
	a_fault_clear: assert property (sts_read && !remote_fault |=>
		!rf_lh_reg) else $error("fault latch not cleared");

	c_soft_reset: cover property ($fell(core_reset));
	c_status_read: cover property (sts_read);
	c_ctl_write: cover property (wr_ctl && !wdat[CTL_RESET]);
	c_read_done: cover property ($fell(mdio_oe));
	c_link_back: cover property ($rose(link_ll_reg));
endmodule : phy_mgmt_regs
`default_nettype wire

// File: inc/phy_mgmt_pkg.sv
/*
 * constants for the management register bank of a 10/100 transceiver.
 * assumes a 200 MHz mclk and a management bus sampled as plain inputs.
 */
package phy_mgmt_pkg;
	// register addresses on the management bus
	localparam logic [4:0]  REG_CONTROL  = 5'h00;
	localparam logic [4:0]  REG_STATUS   = 5'h01;
	localparam logic [4:0]  REG_IDHIGH   = 5'h02;
	// control fields
	localparam int          CTL_RESET    = 15;
	localparam int          CTL_ISOLATE  = 10;
	localparam int          CTL_RESTART  = 9;
	localparam logic [15:0] CTL_DEFAULT  = 16'h3100;
	localparam logic [15:0] CTL_RW_MASK  = 16'h7980;
	// status fields
	localparam logic [15:0] STS_FIXED    = 16'h7809;
	localparam int          STS_AN_DONE  = 5;
	localparam int          STS_RFAULT   = 4;
	localparam int          STS_LINK     = 2;
	localparam int          STS_JABBER   = 1;
	// frame layout
	localparam logic [5:0]  PRE_ONES     = 6'h20;
	localparam logic [5:0]  HDR_LAST     = 6'h0B;
	localparam logic [5:0]  DATA_LAST    = 6'h0F;
	localparam logic [1:0]  OP_READ      = 2'h2;
	localparam logic [1:0]  OP_WRITE     = 2'h1;
	// software reset duration
	localparam int          CLK_NS       = 5;
	localparam int          SOFT_RST_NS  = 500;
	localparam int          SOFT_RST_CYC =
		(SOFT_RST_NS + CLK_NS - 1) / CLK_NS;
	// management frame states
	typedef enum logic [2:0] {
		ST_HUNT, ST_START, ST_HDR, ST_TA1, ST_TA2,
		ST_RDATA, ST_WTA, ST_WDATA
	} mgmt_state_type;
endpackage : phy_mgmt_pkg

// File: tb/mgmt_master.sv
/*
 * station manager model: drives mdc and mdio frames into the bank.
 * assumes mclk is the bank clock; mdc runs at mclk/9.
 */
`timescale 1ns/100ps
`default_nettype none
module mgmt_master
	import phy_mgmt_pkg::*;
(
	// bank clock
	input  wire logic mclk,
	// device side of mdio
	input  wire logic mdio_out,
	input  wire logic mdio_oe,
	// manager side
	output var  logic mdc,
	output var  logic mdio_in
);
	// bus starts high; a read of an odd register leaves it low after the frame
	initial begin
		mdc = 1'b0;
		mdio_in = 1'b1;
	end
	// one mdc period; the device launches a bit on one rise and the
	// manager takes it just before the next rise, as a real manager
	// samples on its own rising edge
	task automatic bit_cyc(input logic b, output logic q, output logic oe);
		@(negedge mclk);
		mdc = 1'b0;
		mdio_in = b;
		repeat (4) @(negedge mclk);
		q = mdio_out;
		oe = mdio_oe;
		mdc = 1'b1;
		repeat (4) @(negedge mclk);
	endtask : bit_cyc
	// whole frame; n_oe counts bit times the device drove
	task automatic frame(input int pre, input logic [4:0] ad,
		input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd, output int n_oe);
		logic [31:0] hdr;
		logic        q;
		logic        oe;
		hdr = {2'b01, op, ad, ra, 2'b10, wd};
		n_oe = 0;
		// short preamble only when a scenario asks for it
		for (int i = 0; i < pre; i++) bit_cyc(1'b1, q, oe);
		for (int i = 31; i >= -1; i--) begin
			// a released line toggles so no stale level passes
			if (op == OP_READ && i < 18)
				bit_cyc(~mdio_in, q, oe);
			else
				bit_cyc(i < 0 ? 1'b1 : hdr[i], q, oe);
			if (i >= 0 && i < 16) rd[i] = q;
			if (oe === 1'b1) n_oe++;
		end
	endtask : frame
endmodule : mgmt_master
`default_nettype wire

// File: tb/testbench.sv
/*
 * self-checking bench for the management register bank.
 * assumes the manager model drives mdc; inputs move at falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench
	import phy_mgmt_pkg::*;
();
	localparam logic [15:0] OUI_TB = 16'h5A3C; // arbitrary value
	// stimulus
	logic       mclk, resetn, an_done, remote_fault, link_up, jabber;
	logic [4:0] strap;
	// bus and control pins
	wire logic  mdc, mdio_in, mdio_out, mdio_oe, core_reset, loopback_en;
	wire logic  speed_100, an_enable, low_power, isolate, an_restart;
	wire logic  full_duplex;
	wire logic [7:0] pins;
	logic [15:0] v;
	int          n_fail      = 0; // mismatches
	int          check_count = 0; // comparisons made
	int          n_restart   = 0; // cycles with restart high
	int          n_core      = 0; // cycles spent in soft reset
	assign pins = {core_reset, loopback_en, speed_100, an_enable,
		low_power, isolate, an_restart, full_duplex};
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// count pulse and reset cycles, as single edges are easy to miss
	always @(posedge mclk) begin
		if (an_restart === 1'b1) n_restart <= n_restart + 1;
		if (core_reset === 1'b1) n_core <= n_core + 1;
	end
	phy_mgmt_regs #(.OUI_HIGH(OUI_TB)) i_dut (.mclk(mclk),
		.resetn(resetn), .mdc(mdc), .mdio_in(mdio_in),
		.mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr_strap(strap),
		.an_done(an_done), .remote_fault(remote_fault),
		.link_up(link_up), .jabber(jabber), .core_reset(core_reset),
		.loopback_en(loopback_en), .speed_100(speed_100),
		.an_enable(an_enable), .low_power(low_power), .isolate(isolate),
		.an_restart(an_restart), .full_duplex(full_duplex));
	mgmt_master i_mgr (.mclk(mclk), .mdio_out(mdio_out),
		.mdio_oe(mdio_oe), .mdc(mdc), .mdio_in(mdio_in));
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic check(input logic [15:0] seen, exp, input string s);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: %s seen %h want %h", $time, s, seen, exp);
		end
	endtask : check
	task automatic rd(input logic [4:0] ra, output logic [15:0] d);
		int n;
		i_mgr.frame(32, strap, OP_READ, ra, 16'h0000, d, n);
		check(16'(n), 16'h0011, "read drive");
	endtask : rd
	task automatic wr(input int p, input logic [4:0] a, input logic [15:0] d);
		int          n;
		logic [15:0] r;
		i_mgr.frame(p, a, OP_WRITE, REG_CONTROL, d, r, n);
		check(16'(n), 16'h0000, "write drive");
	endtask : wr
	task automatic do_reset;
		resetn = 1'b0;
		repeat (10) @(negedge mclk);
		resetn = 1'b1;
	endtask : do_reset
	task automatic t_ctrl;
		rd(REG_CONTROL, v);
		check(v, 16'h3100, "ctl default");
		check({8'h00, pins}, 16'h0031, "pins default");
		wr(32, strap, 16'h7DFF);
		rd(REG_CONTROL, v);
		check(v, 16'h7D80, "ctl set");
		check({8'h00, pins}, 16'h007D, "pins set");
		wr(32, strap, 16'h0000);
		rd(REG_CONTROL, v);
		check(v, 16'h0400, "ctl clear");
		check({8'h00, pins}, 16'h0004, "pins clear");
		$display("test ctrl done");
	endtask : t_ctrl
	task automatic t_restart_refuse;
		int k;
		k = n_restart;
		wr(32, strap, 16'h0200);
		check(16'(n_restart - k), 16'h0001, "restart pulse");
		// the idle one after the last frame counts as preamble too,
		// so 30 here leaves the device one short of a full preamble
		wr(30, strap, 16'h4000);
		wr(32, strap + 5'h01, 16'h4000);
		rd(REG_CONTROL, v);
		check(v, 16'h0400, "restart clear, refused");
		$display("test restart done");
	endtask : t_restart_refuse
	task automatic t_soft;
		int k;
		int i;
		k = n_core;
		wr(32, strap, 16'h8000);
		for (i = 0; i < 300 && core_reset !== 1'b0; i++) @(negedge mclk);
		if (i == 300) begin
			n_fail++;
			$display("Error at %0t: soft reset stuck", $time);
			print_verdict();
		end
		check(16'(n_core - k), 16'(SOFT_RST_CYC), "reset len");
		rd(REG_CONTROL, v);
		check(v, 16'h3100, "ctl after reset");
		check({8'h00, pins}, 16'h0031, "pins after");
		$display("test soft reset done");
	endtask : t_soft
	task automatic t_status;
		rd(REG_STATUS, v);
		check(v, 16'h7809, "status 1");
		rd(REG_STATUS, v);
		check(v, 16'h780D, "status 2");
		@(negedge mclk);
		{an_done, remote_fault, jabber, link_up} = 4'hE;
		@(negedge mclk);
		{an_done, remote_fault, jabber, link_up} = 4'h1;
		rd(REG_STATUS, v);
		check(v, 16'h783B, "status 3");
		rd(REG_STATUS, v);
		check(v, 16'h780D, "status 4");
		rd(REG_IDHIGH, v);
		check(v, OUI_TB, "ident");
		rd(5'h05, v);
		check(v, 16'h0000, "unmapped");
		$display("test status done");
	endtask : t_status
	task automatic t_strap0;
		strap = 5'h00;
		do_reset();
		check({8'h00, pins}, 16'h0035, "iso pin");
		rd(REG_CONTROL, v);
		check(v, 16'h3500, "iso default");
		$display("test strap done");
	endtask : t_strap0
	// main sequence
	initial begin
		{resetn, an_done, remote_fault, jabber, link_up} = 5'h01;
		strap = 5'h01;
		do_reset();
		t_ctrl();
		t_restart_refuse();
		t_soft();
		t_status();
		t_strap0();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
